// >>> design/nsx_pkg.sv
// Package with opcode patterns, field positions and widths for the nibble/xor/direction executor
package nsx_pkg;
    localparam int          NSX_DATA_W     = 8;
    localparam int          NSX_INSN_W     = 12;
    localparam int          NSX_FADDR_W    = 5;
    localparam int          NSX_DIR_SEL_W  = 3;
    // Opcode match masks and values on the 12-bit instruction word
    localparam logic [11:0] NSX_MASK_FD    = 12'hFC0;
    localparam logic [11:0] NSX_OP_SWAP    = 12'h380;
    localparam logic [11:0] NSX_OP_REG_XOR = 12'h180;
    localparam logic [11:0] NSX_MASK_LIT   = 12'hF00;
    localparam logic [11:0] NSX_OP_LIT_XOR = 12'hF00;
    localparam logic [11:0] NSX_MASK_DIR   = 12'hFF8;
    localparam logic [11:0] NSX_OP_DIR     = 12'h000;
    // Field positions
    localparam int          NSX_DEST_BIT   = 5;
    localparam int          NSX_LIT_MSB    = 7;
    localparam int          NSX_FADDR_MSB  = 4;
    localparam int          NSX_DIR_MSB    = 2;
    localparam logic [2:0]  NSX_DIR_FIRST  = 3'h6;
    localparam logic [2:0]  NSX_DIR_LAST   = 3'h7;
    localparam int          NSX_DIR_COUNT  = 2;
    localparam logic [7:0]  NSX_RESET_DATA = 8'h00;
    localparam logic [7:0]  NSX_DIR_RESET  = 8'hFF;
endpackage

// >>> design/nsx_decode.sv
// Combinational opcode classifier for the four handled instructions
`timescale 1ns/1ns
module nsx_decode import nsx_pkg::*; (
    input  wire logic [NSX_INSN_W-1:0] insn,
    input  wire logic                  insn_valid,
    output logic                       is_nibble_exchange_op,
    output logic                       is_direction_load_op,
    output logic                       is_literal_exclusive_or_op,
    output logic                       is_register_exclusive_or_op
);
    // Pattern matches gated by the fetch strobe
    always_comb begin
        is_nibble_exchange_op       = insn_valid && ((insn & NSX_MASK_FD) == NSX_OP_SWAP);
        is_register_exclusive_or_op = insn_valid && ((insn & NSX_MASK_FD) == NSX_OP_REG_XOR);
        is_literal_exclusive_or_op  = insn_valid && ((insn & NSX_MASK_LIT) == NSX_OP_LIT_XOR);
        // Operands outside 6..7 are not direction loads and are ignored
        is_direction_load_op        = insn_valid && ((insn & NSX_MASK_DIR) == NSX_OP_DIR)
                                      && (insn[NSX_DIR_MSB:0] >= NSX_DIR_FIRST);
    end
endmodule // nsx_decode

// >>> design/nsx_exec.sv
// Execution unit for nibble exchange, direction load and the two exclusive OR instructions
`timescale 1ns/1ns
// Operation
// - Nibble exchange puts the low nibble of the file register on top and the high nibble below, flags untouched.
// - Nibble exchange writes the accumulator when the destination bit is 0 and the file register when it is 1.
// - Direction load copies the accumulator into direction register 6 or 7 chosen by the operand, flags untouched.
// - Literal exclusive OR combines accumulator and 8-bit literal, writes the accumulator and updates the null flag.
// - Register exclusive OR combines accumulator and file register 0..31 and updates the null flag.
// - Register exclusive OR writes the accumulator when the destination bit is 0 and the file register when it is 1.
module nsx_exec import nsx_pkg::*; #(
    parameter int DATA_W = NSX_DATA_W
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic [NSX_INSN_W-1:0]    insn,
    input  wire logic                     insn_valid,
    input  wire logic [DATA_W-1:0]        file_rdata,
    output logic      [NSX_FADDR_W-1:0]   file_addr,
    output logic                          file_we,
    output logic      [DATA_W-1:0]        file_wdata,
    output logic      [DATA_W-1:0]        acc,
    output logic                          result_null,
    output logic      [DATA_W-1:0]        dir_port6,
    output logic      [DATA_W-1:0]        dir_port7,
    output logic                          fetch_stall
);
    if (DATA_W != NSX_DATA_W) begin : g_bad_width
        $error("nsx_exec supports only 8-bit data");
    end

    logic                  op_swap;
    logic                  op_dir;
    logic                  op_lit_xor;
    logic                  op_reg_xor;
    logic                  dest_file;
    logic [DATA_W-1:0]     swapped;
    logic [DATA_W-1:0]     xor_result;
    logic [DATA_W-1:0]     next_acc;
    logic                  next_result_null;
    logic [DATA_W-1:0]     next_dir [NSX_DIR_COUNT];
    logic [DATA_W-1:0]     dir_q    [NSX_DIR_COUNT];
    logic                  next_file_we;
    logic [DATA_W-1:0]     next_file_wdata;

    nsx_decode u_decode (
        .insn                        (insn),
        .insn_valid                  (insn_valid),
        .is_nibble_exchange_op       (op_swap),
        .is_direction_load_op        (op_dir),
        .is_literal_exclusive_or_op  (op_lit_xor),
        .is_register_exclusive_or_op (op_reg_xor)
    );

    // File address is driven straight from the operand so the read completes in the same cycle
    assign file_addr   = insn[NSX_FADDR_MSB:0];
    assign dest_file   = insn[NSX_DEST_BIT];
    assign fetch_stall = 1'h0;

    // Datapath results
    always_comb begin
        // Halves follow the data width so no nibble boundary is hard-wired
        swapped = {file_rdata[DATA_W/2-1:0], file_rdata[DATA_W-1:DATA_W/2]};
        if (op_lit_xor) begin
            xor_result = acc ^ insn[NSX_LIT_MSB:0];
        end else begin
            xor_result = acc ^ file_rdata;
        end
    end

    // Next accumulator, null flag and file write; only the XOR forms touch the flag
    always_comb begin
        next_acc         = acc;
        next_result_null = result_null;
        next_file_we     = 1'h0;
        next_file_wdata  = file_wdata;
        if (op_swap) begin
            if (dest_file) begin
                next_file_we    = 1'h1;
                next_file_wdata = swapped;
            end else begin
                next_acc = swapped;
            end
        end else if (op_lit_xor) begin
            next_acc         = xor_result;
            next_result_null = (xor_result == NSX_RESET_DATA);
        end else if (op_reg_xor) begin
            next_result_null = (xor_result == NSX_RESET_DATA);
            if (dest_file) begin
                next_file_we    = 1'h1;
                next_file_wdata = xor_result;
            end else begin
                next_acc = xor_result;
            end
        end
    end

    // One direction register per loadable port
    for (genvar i = 0; i < NSX_DIR_COUNT; i++) begin : g_dir
        always_comb begin
            next_dir[i] = dir_q[i];
            if (op_dir && (insn[NSX_DIR_MSB:0] == NSX_DIR_FIRST + 3'(i))) begin
                next_dir[i] = acc;
            end
        end
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                dir_q[i] <= NSX_DIR_RESET; // Ports start as inputs
            end else begin
                dir_q[i] <= next_dir[i];
            end
        end
    end

    assign dir_port6 = dir_q[0];
    assign dir_port7 = dir_q[1];

    // Architectural state registers; the file write is a registered one-cycle strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc         <= NSX_RESET_DATA;
            result_null <= 1'h0;
            file_we     <= 1'h0;
            file_wdata  <= NSX_RESET_DATA;
        end else begin
            acc         <= next_acc;
            result_null <= next_result_null;
            file_we     <= next_file_we;
            file_wdata  <= next_file_wdata;
        end
    end
endmodule // nsx_exec

// >>> verif/nsx_exec_asserts.sv
// Property checker for the nibble exchange, direction load and exclusive OR executor
`timescale 1ns/1ns
module nsx_exec_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [11:0] insn,
    input wire logic        insn_valid,
    input wire logic [7:0]  file_rdata,
    input wire logic [4:0]  file_addr,
    input wire logic        file_we,
    input wire logic [7:0]  file_wdata,
    input wire logic [7:0]  acc,
    input wire logic        result_null,
    input wire logic [7:0]  dir_port6,
    input wire logic [7:0]  dir_port7,
    input wire logic        fetch_stall
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Opcode classes and expected results, taken from the inputs of the executing cycle
    wire       sw = insn_valid && insn[11:6] == 6'h0E;
    wire       dl = insn_valid && insn[11:1] == 11'h003;
    wire       xl = insn_valid && insn[11:8] == 4'hF;
    wire       xw = insn_valid && insn[11:6] == 6'h06;
    wire [7:0] sx = {file_rdata[3:0], file_rdata[7:4]};
    wire [7:0] xr = acc ^ file_rdata;
    wire [7:0] xk = acc ^ insn[7:0];
    swap_acc_a: assert property (sw && !insn[5] |=> acc == $past(sx) && $stable(result_null))
        else $error("nibble exchange to acc wrong");
    swap_file_a: assert property (sw && insn[5] |=> file_we && file_wdata == $past(sx) && $stable(acc))
        else $error("nibble exchange write-back wrong");
    dir_load_a: assert property (dl |=> ($past(insn[0]) ? dir_port7 : dir_port6) == $past(acc)
        && $stable(result_null))
        else $error("direction load wrong");
    lit_xor_a: assert property (xl |=> acc == $past(xk) && result_null == (acc == 8'h00))
        else $error("literal xor wrong");
    reg_null_a: assert property (xw |=> result_null == ($past(xr) == 8'h00))
        else $error("register xor flag wrong");
    reg_dest_a: assert property (xw |=> file_we == $past(insn[5])
        && ($past(insn[5]) ? file_wdata == $past(xr) : acc == $past(xr)))
        else $error("register xor destination wrong");
    no_stall_a: assert property (!fetch_stall)
        else $error("fetch stalled");
    cover property (sw && insn[5] ##1 file_we);
    cover property (dl);
    cover property (xw ##1 result_null);
endmodule // nsx_exec_chk
bind nsx_exec nsx_exec_chk chk (.clk(clk), .rst_n(rst_n), .insn(insn), .insn_valid(insn_valid),
    .file_rdata(file_rdata), .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata), .acc(acc),
    .result_null(result_null), .dir_port6(dir_port6), .dir_port7(dir_port7), .fetch_stall(fetch_stall));

// >>> verif/tb.sv
// Self-checking bench for the nibble exchange, direction load and exclusive OR executor
`timescale 1ns/1ns
module tb;
    logic        clk = 1'h0, rst_n = 1'h0, insn_valid = 1'h0, file_we, result_null, fetch_stall;
    logic [11:0] insn = 12'h000;
    logic [7:0]  file_rdata = 8'h00, file_wdata, acc, dir_port6, dir_port7;
    logic [4:0]  file_addr;
    int          n_errors = 0, cmp_count = 0, cyc = 0;
    always #50 clk = ~clk;
    nsx_exec uut (.clk(clk), .rst_n(rst_n), .insn(insn), .insn_valid(insn_valid), .file_rdata(file_rdata),
        .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata), .acc(acc), .result_null(result_null),
        .dir_port6(dir_port6), .dir_port7(dir_port7), .fetch_stall(fetch_stall));
    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One instruction; results are read just after the edge that executes it
    task automatic run(logic [11:0] i, logic [7:0] r, logic [7:0] ea, logic en, logic ew, logic [7:0] wd);
        @(posedge clk);
        insn <= i;
        insn_valid <= 1'h1;
        file_rdata <= r;
        #1 chk("addr", {3'h0, file_addr}, {3'h0, i[4:0]});
        chk("we_idle", {7'h00, file_we}, 8'h00);
        @(posedge clk);
        insn_valid <= 1'h0;
        #1 chk("acc", acc, ea);
        chk("null", {7'h00, result_null}, {7'h00, en});
        chk("we", {7'h00, file_we}, {7'h00, ew});
        if (ew) chk("wdata", file_wdata, wd);
        chk("stall", {7'h00, fetch_stall}, 8'h00);
    endtask
    // Literal xor chain ending on a zero result, so the null flag is set for the next test
    task automatic t_lit;
        run(12'hFB5, 8'h00, 8'hB5, 1'h0, 1'h0, 8'h00);
        run(12'hFFF, 8'h00, 8'h4A, 1'h0, 1'h0, 8'h00);
        run(12'hF4A, 8'h00, 8'h00, 1'h1, 1'h0, 8'h00);
    endtask
    // Nibble exchange to acc, then back to file 31; the set flag must survive
    task automatic t_swap;
        run(12'h383, 8'hA5, 8'h5A, 1'h1, 1'h0, 8'h00);
        run(12'h3BF, 8'hC3, 8'h5A, 1'h1, 1'h1, 8'h3C);
    endtask
    // Both direction registers, then a refused operand after acc changed
    task automatic t_dir;
        run(12'h006, 8'h00, 8'h5A, 1'h1, 1'h0, 8'h00);
        chk("dir7", dir_port7, 8'hFF);
        run(12'h007, 8'h00, 8'h5A, 1'h1, 1'h0, 8'h00);
        run(12'hFFF, 8'h00, 8'hA5, 1'h0, 1'h0, 8'h00);
        run(12'h005, 8'h00, 8'hA5, 1'h0, 1'h0, 8'h00);
        chk("dir6", dir_port6, 8'h5A);
        chk("dir7", dir_port7, 8'h5A);
    endtask
    // Register xor to acc, then to files 0 and 31
    task automatic t_xw;
        run(12'h185, 8'hA5, 8'h00, 1'h1, 1'h0, 8'h00);
        run(12'h1A0, 8'h0F, 8'h00, 1'h0, 1'h1, 8'h0F);
        run(12'h1BF, 8'h00, 8'h00, 1'h1, 1'h1, 8'h00);
    endtask
    // Two instructions on consecutive edges; the second uses the acc the first produced
    task automatic t_b2b;
        @(posedge clk);
        insn <= 12'hF3C;
        insn_valid <= 1'h1;
        @(posedge clk);
        insn <= 12'h1A2;
        file_rdata <= 8'hFF;
        #1 chk("acc", acc, 8'h3C);
        chk("null", {7'h00, result_null}, 8'h00);
        chk("addr", {3'h0, file_addr}, 8'h02);
        @(posedge clk);
        insn_valid <= 1'h0;
        #1 chk("we", {7'h00, file_we}, 8'h01);
        chk("wdata", file_wdata, 8'hC3);
        chk("acc", acc, 8'h3C);
        chk("null", {7'h00, result_null}, 8'h00);
    endtask
    // Reset in mid-run clears acc and the null flag and sets both direction registers to FF, then execution resumes from a clear acc
    task automatic t_rst;
        @(posedge clk);
        rst_n <= 1'h0;
        @(posedge clk);
        rst_n <= 1'h1;
        #1 chk("acc", acc, 8'h00);
        chk("null", {7'h00, result_null}, 8'h00);
        chk("dir6", dir_port6, 8'hFF);
        chk("dir7", dir_port7, 8'hFF);
        run(12'hF01, 8'h00, 8'h01, 1'h0, 1'h0, 8'h00);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard; the whole run needs about 34 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 500) begin
            n_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        chk("dir6", dir_port6, 8'hFF);
        rst_n <= 1'h1;
        t_lit();
        t_swap();
        t_dir();
        t_xw();
        t_b2b();
        t_rst();
        give_verdict();
    end
endmodule // tb
